// File: design/msc_pkg.sv
// Constants, types and state codes of the command interpreter of the serial slave.
// Assumes a layer-2 framer on the same clock that strips framing and checksum.
// Functional notes
// - Accept function codes 01, 02, 03, 04, 05, 06, 15 and 16.
// - Normal responses follow the standard protocol format for each function.
// - Exception responses are suppressed unless the exception-enable setting is on.
// - Exception codes are 01 function, 02 address, 03 value, 04 device failure.
// - Byte count, point count and byte-count field mismatches give illegal data value.
// - In ASCII framing each payload byte counts as two received characters.
// - Out-of-range address aborts whole command; first faulting bank and address are kept.
// - Application error stops at faulting item, earlier items done; bank and address kept.
// - Function code alone selects coil, discrete, input or holding space; address used directly.
// - Same address value in coil and holding spaces reaches different registers.
// - Master retrieves a dataset first; holding and discrete reads are served from that frozen copy.
// - Retrieving a dataset for writing locks out front-panel changes while held.
// - Multi-word register sets are valid only when accessed whole from the first word.
// - A register set is validated as one value when its high word is written.
// - Changing a parent parameter adjusts invalid dependents automatically.
// - Dependents sit above their parent so one ascending write updates both.
// - Changes are stored when the write timer expires and applied at next cycle start.
// - A cycle-log record is appended when control moves from dosing to return.
// - Daily log rolls at the day boundary time and today refreshes every second.
// - At the day boundary entry 1 becomes entry 2 and entry 7 is discarded.
// - Broadcast address zero commands execute but never get a response.
// - Only the configured station address 1 to 247, default 1, is answered.
// - After a device failure the failure type code is readable at input register 1000.
// - Commands and responses are at most 256 bytes long.
package msc_pkg;
	localparam logic [7:0] FC_RD_COILS = 8'h01;
	localparam logic [7:0] FC_RD_DISC = 8'h02;
	localparam logic [7:0] FC_RD_HOLD = 8'h03;
	localparam logic [7:0] FC_RD_INP = 8'h04;
	localparam logic [7:0] FC_WR_COIL = 8'h05;
	localparam logic [7:0] FC_WR_REG = 8'h06;
	localparam logic [7:0] FC_WR_COILS = 8'h0f;
	localparam logic [7:0] FC_WR_REGS = 8'h10;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
	localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
	localparam logic [7:0] EXC_DEV_FAIL = 8'h04;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_NOT_LOCKED = 16'h0006;
	localparam logic [15:0] ERR_ALREADY_LOCKED = 16'h0008;
	localparam logic [15:0] ERR_WR_SEQ = 16'h000a;
	localparam logic [15:0] BANK_COIL = 16'h0000;
	localparam logic [15:0] BANK_DISC = 16'h0001;
	localparam logic [15:0] BANK_INP = 16'h0003;
	localparam logic [15:0] BANK_HOLD = 16'h0004;
	localparam int N_COIL = 32;
	localparam int N_DISC = 16;
	localparam int N_HOLD = 32;
	localparam int N_LOG = 7;
	localparam logic [16:0] SET_BASE = 17'h00010;
	localparam logic [16:0] DEP_N = 17'h00008;
	localparam logic [16:0] COIL_RETRIEVE = 17'h00000;
	localparam logic [16:0] COIL_LOCK = 17'h00001;
	localparam logic [16:0] COIL_RELEASE = 17'h00002;
	localparam logic [16:0] INP_LOG_BASE = 17'h00064;
	localparam logic [16:0] INP_FAULT_CODE = 17'h003e8;
	localparam logic [16:0] INP_FAULT_BANK = 17'h003e9;
	localparam logic [16:0] INP_FAULT_ADDR = 17'h003ea;
	localparam logic [8:0] MAX_FRAME = 9'h100;
	localparam logic [15:0] MAX_RD_BITS = 16'h07d0;
	localparam logic [15:0] MAX_RD_REGS = 16'h007d;
	localparam logic [15:0] MAX_WR_BITS = 16'h07b0;
	localparam logic [15:0] MAX_WR_REGS = 16'h007b;
	localparam logic [8:0] LEN_FIXED = 9'h006;
	localparam logic [8:0] LEN_MULTI = 9'h007;
	localparam logic [8:0] LEN_EXC = 9'h003;
	localparam logic [7:0] STATION_DEF = 8'h01;
	localparam logic [7:0] STATION_MAX = 8'hf7;
	localparam logic [7:0] BROADCAST = 8'h00;
	localparam logic [15:0] COIL_ON = 16'hff00;
	localparam logic [15:0] COIL_OFF = 16'h0000;
	localparam longint CLK_HZ = 125000000;
	localparam longint WRITE_TIME_MS = 1000;
	localparam longint SECOND_S = 1;
	localparam int unsigned WRITE_TIME_CYCLES = int'(CLK_HZ / 1000 * WRITE_TIME_MS);
	localparam int unsigned SECOND_CYCLES = int'(CLK_HZ * SECOND_S);
	typedef enum logic [2:0] {S_IDLE, S_EVAL, S_CHECK, S_EXEC, S_TX} msc_state_t;
	typedef struct packed {
		logic [15:0] code;
		logic [15:0] bank;
		logic [15:0] addr;
	} msc_fault_t;
	typedef struct packed {
		logic [7:0] slave;
		logic [7:0] fc;
		logic [15:0] start;
		logic [15:0] cnt;
		logic [7:0] bc;
	} msc_hdr_t;
endpackage : msc_pkg

// File: design/msc_command_handler.sv
// Command interpreter: decodes a received frame, checks it, executes it and streams the answer.
// Assumes the framer delivers payload bytes and an end pulse on clk_sys and adds the checksum.
`timescale 1ns/1ps
`default_nettype none
module msc_command_handler #(
	parameter int unsigned WRITE_CYCLES = msc_pkg::WRITE_TIME_CYCLES,
	parameter int unsigned SECOND_TICKS = msc_pkg::SECOND_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_end,
	input wire logic [9:0] rx_chars,
	input wire logic ascii_mode,
	input wire logic [7:0] station_addr,
	input wire logic exc_enable,
	input wire logic fp_busy,
	input wire logic [15:0] disc_live,
	input wire logic cycle_start,
	input wire logic cycle_restart,
	input wire logic dose_phase,
	input wire logic return_phase,
	input wire logic [16:0] sec_of_day,
	input wire logic [16:0] day_start,
	input wire logic [15:0] today_prod,
	input wire logic [4:0] ctrl_rd_addr,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	output logic fp_lock,
	output logic [15:0] ctrl_rd_data,
	output logic cycle_log_append,
	output logic day_roll
);
	import msc_pkg::*;

	logic [7:0] rx_buf [256];
	logic [8:0] nb;
	logic overflow;
	msc_state_t state;
	msc_hdr_t hdr;
	msc_fault_t fault;
	logic [7:0] exc;
	logic [15:0] idx;
	logic [8:0] ti;
	logic [16:0] a;
	logic [15:0] bank;
	logic [15:0] items;
	logic is_bit;
	logic is_write;
	logic len_ok;
	logic ill_func;
	logic char_ok;
	logic a_ok;
	logic [7:0] station;
	logic respond;
	logic [8:0] rd_bc;
	logic [8:0] tlen;
	logic [7:0] next_tx;
	logic [15:0] wval;
	logic bval;
	logic [15:0] app_err;
	logic exec_go;
	logic wr_coil;
	logic wr_hold;
	logic set_lo;
	logic set_hi;
	logic lock;
	logic pend_valid;
	logic [4:0] pend_addr;
	logic [15:0] pend_word;
	logic [N_COIL-1:0] coils;
	logic [N_DISC-1:0] disc_snap;
	logic [15:0] hold_work [N_HOLD];
	logic [15:0] hold_saved [N_HOLD];
	logic [15:0] hold_active [N_HOLD];
	logic [15:0] hold_snap [N_HOLD];
	logic [15:0] day_log [N_LOG];
	logic wt_armed;
	logic [31:0] wt_cnt;
	logic commit;
	logic apply_req;
	logic [31:0] sec_cnt;
	logic tick;
	logic dose_q;

	assign hdr = {rx_buf[0], rx_buf[1], rx_buf[2], rx_buf[3], rx_buf[4], rx_buf[5], rx_buf[6]};
	assign a = {1'b0, hdr.start} + {1'b0, idx};
	assign station = (station_addr == BROADCAST || station_addr > STATION_MAX) ?
		STATION_DEF : station_addr;
	assign respond = (hdr.slave != BROADCAST) && (exc == EXC_NONE || exc_enable);
	assign char_ok = rx_chars == (ascii_mode ? {nb, 1'b0} : {1'b0, nb});
	assign fp_lock = lock;

	// Function decode and length consistency checks.
	always_comb
	begin
		is_bit = 1'b0;
		is_write = 1'b0;
		bank = BANK_HOLD;
		len_ok = 1'b0;
		ill_func = 1'b0;
		items = hdr.cnt;
		unique case (hdr.fc)
			FC_RD_COILS, FC_RD_DISC:
			begin
				is_bit = 1'b1;
				bank = (hdr.fc == FC_RD_COILS) ? BANK_COIL : BANK_DISC;
				len_ok = nb == LEN_FIXED && hdr.cnt != 16'h0000 && hdr.cnt <= MAX_RD_BITS;
			end
			FC_RD_HOLD, FC_RD_INP:
			begin
				bank = (hdr.fc == FC_RD_HOLD) ? BANK_HOLD : BANK_INP;
				len_ok = nb == LEN_FIXED && hdr.cnt != 16'h0000 && hdr.cnt <= MAX_RD_REGS;
			end
			FC_WR_COIL:
			begin
				is_bit = 1'b1;
				is_write = 1'b1;
				bank = BANK_COIL;
				items = 16'h0001;
				len_ok = nb == LEN_FIXED && (hdr.cnt == COIL_ON || hdr.cnt == COIL_OFF);
			end
			FC_WR_REG:
			begin
				is_write = 1'b1;
				items = 16'h0001;
				len_ok = nb == LEN_FIXED;
			end
			FC_WR_COILS:
			begin
				is_bit = 1'b1;
				is_write = 1'b1;
				bank = BANK_COIL;
				len_ok = {1'b0, nb} == {2'b00, LEN_MULTI[7:0]} + {2'b00, hdr.bc} &&
					{9'h000, hdr.bc} == 17'((hdr.cnt + 17'd7) >> 3) &&
					hdr.cnt != 16'h0000 && hdr.cnt <= MAX_WR_BITS;
			end
			FC_WR_REGS:
			begin
				is_write = 1'b1;
				len_ok = {1'b0, nb} == {2'b00, LEN_MULTI[7:0]} + {2'b00, hdr.bc} &&
					{9'h000, hdr.bc} == {hdr.cnt, 1'b0} &&
					hdr.cnt != 16'h0000 && hdr.cnt <= MAX_WR_REGS;
			end
			default:
				ill_func = 1'b1;
		endcase
	end

	// Address range of each space.
	always_comb
	begin
		if (bank == BANK_COIL)
			a_ok = a < 17'(N_COIL);
		else if (bank == BANK_DISC)
			a_ok = a < 17'(N_DISC);
		else if (bank == BANK_HOLD)
			a_ok = a < 17'(N_HOLD);
		else
			a_ok = (a >= INP_LOG_BASE && a < INP_LOG_BASE + 17'(N_LOG)) ||
				(a >= INP_FAULT_CODE && a <= INP_FAULT_ADDR);
	end

	// Value of the current write item and its application checks.
	always_comb
	begin
		wval = hdr.cnt;
		bval = hdr.cnt == COIL_ON;
		if (hdr.fc == FC_WR_COILS)
			bval = rx_buf[8'(16'd7 + (idx >> 3))][idx[2:0]];
		if (hdr.fc == FC_WR_REGS)
			wval = {rx_buf[8'(16'd7 + {idx[14:0], 1'b0})], rx_buf[8'(16'd8 + {idx[14:0], 1'b0})]};
		set_lo = !is_bit && a >= SET_BASE && !a[0];
		set_hi = !is_bit && a >= SET_BASE && a[0];
		app_err = ERR_NONE;
		if (is_bit && a == COIL_LOCK && bval && fp_busy)
			app_err = ERR_ALREADY_LOCKED;
		else if (!is_bit && !lock)
			app_err = ERR_NOT_LOCKED;
		else if (set_hi && !(pend_valid && pend_addr == 5'(a - 17'd1)))
			app_err = ERR_WR_SEQ;
	end

	assign exec_go = state == S_EXEC && app_err == ERR_NONE;
	assign wr_coil = exec_go && is_bit;
	assign wr_hold = exec_go && !is_bit;

	// Answer length and the byte at position ti.
	always_comb
	begin
		logic [16:0] bi;
		logic [16:0] wa;
		logic [8:0] d;
		logic [15:0] w;
		bi = 17'h00000;
		wa = 17'h00000;
		w = 16'h0000;
		d = ti - 9'd3;
		rd_bc = is_bit ? 9'((hdr.cnt + 17'd7) >> 3) : 9'({hdr.cnt, 1'b0});
		tlen = exc != EXC_NONE ? LEN_EXC : (is_write ? LEN_FIXED : LEN_EXC + rd_bc);
		next_tx = rx_buf[ti[7:0]];
		if (ti == 9'd1)
			next_tx = exc != EXC_NONE ? (hdr.fc | EXC_FLAG) : hdr.fc;
		else if (ti == 9'd2 && exc != EXC_NONE)
			next_tx = exc;
		else if (ti == 9'd2 && !is_write)
			next_tx = rd_bc[7:0];
		else if (ti >= 9'd3 && !is_write && is_bit)
		begin
			for (int k = 0; k < 8; k++)
			begin
				bi = {5'h00, d, 3'b000} + 17'(k);
				wa = {1'b0, hdr.start} + bi;
				if (bi >= {1'b0, hdr.cnt})
					next_tx[k] = 1'b0;
				else if (hdr.fc == FC_RD_COILS)
					next_tx[k] = wa < 17'(N_COIL) && wa > COIL_RELEASE && coils[wa[4:0]];
				else
					next_tx[k] = wa < 17'(N_DISC) && disc_snap[wa[3:0]];
			end
		end
		else if (ti >= 9'd3 && !is_write)
		begin
			wa = {1'b0, hdr.start} + {9'h000, d[8:1]};
			if (hdr.fc == FC_RD_HOLD)
				w = hold_snap[wa[4:0]];
			else if (wa == INP_FAULT_CODE)
				w = fault.code;
			else if (wa == INP_FAULT_BANK)
				w = fault.bank;
			else if (wa == INP_FAULT_ADDR)
				w = fault.addr;
			else if (wa >= INP_LOG_BASE && wa < INP_LOG_BASE + 17'(N_LOG))
				w = day_log[3'(wa - INP_LOG_BASE)];
			next_tx = d[0] ? w[7:0] : w[15:8];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (state == S_IDLE && rx_valid && nb < MAX_FRAME)
			rx_buf[nb[7:0]] <= rx_data;
	end

	// Frame sequencing from reception to the last answer byte.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= S_IDLE;
			nb <= 9'h000;
			overflow <= 1'b0;
			exc <= EXC_NONE;
			idx <= 16'h0000;
			ti <= 9'h000;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_last <= 1'b0;
		end
		else
		begin
			unique case (state)
				S_IDLE:
				begin
					exc <= EXC_NONE;
					idx <= 16'h0000;
					ti <= 9'h000;
					if (rx_valid && nb < MAX_FRAME)
						nb <= nb + 9'd1;
					else if (rx_valid)
						overflow <= 1'b1;
					if (rx_end)
					begin
						nb <= 9'h000;
						overflow <= 1'b0;
						if (!overflow && nb >= 9'd2 && (hdr.slave == station || hdr.slave == BROADCAST))
						begin
							nb <= nb;
							state <= S_EVAL;
						end
					end
				end
				S_EVAL:
				begin
					if (ill_func)
					begin
						exc <= EXC_ILL_FUNC;
						state <= S_TX;
					end
					else if (!len_ok || !char_ok)
					begin
						exc <= EXC_ILL_VALUE;
						state <= S_TX;
					end
					else
						state <= S_CHECK;
				end
				S_CHECK:
				begin
					if (!a_ok)
					begin
						exc <= EXC_ILL_ADDR;
						state <= S_TX;
					end
					else if (idx == items - 16'd1)
					begin
						idx <= 16'h0000;
						state <= is_write ? S_EXEC : S_TX;
					end
					else
						idx <= idx + 16'd1;
				end
				S_EXEC:
				begin
					if (app_err != ERR_NONE)
					begin
						exc <= EXC_DEV_FAIL;
						state <= S_TX;
					end
					else if (idx == items - 16'd1)
						state <= S_TX;
					else
						idx <= idx + 16'd1;
				end
				S_TX:
				begin
					if (!respond)
					begin
						nb <= 9'h000;
						state <= S_IDLE;
					end
					else if (!tx_valid || tx_ready)
					begin
						if (ti < tlen)
						begin
							tx_valid <= 1'b1;
							tx_data <= next_tx;
							tx_last <= ti == tlen - 9'd1;
							ti <= ti + 9'd1;
						end
						else
						begin
							tx_valid <= 1'b0;
							tx_last <= 1'b0;
							nb <= 9'h000;
							state <= S_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Faulting bank and address, plus failure type after an application error.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			fault <= '0;
		else if (state == S_CHECK && !a_ok)
			fault <= {fault.code, bank, a[15:0]};
		else if (state == S_EXEC && app_err != ERR_NONE)
			fault <= {app_err, bank, a[15:0]};
	end

	// Coil storage, dataset retrieval and lock.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			coils <= '0;
			disc_snap <= '0;
			lock <= 1'b0;
		end
		else if (wr_coil)
		begin
			coils[a[4:0]] <= bval;
			if (a == COIL_RETRIEVE && bval)
				disc_snap <= disc_live;
			if (a == COIL_LOCK && bval)
				lock <= 1'b1;
			if (a == COIL_RELEASE && bval)
				lock <= 1'b0;
		end
	end

	// Low word of a register set waits here until its high word arrives.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pend_valid <= 1'b0;
			pend_addr <= 5'h00;
			pend_word <= 16'h0000;
		end
		else if (wr_hold)
		begin
			pend_valid <= set_lo;
			pend_addr <= a[4:0];
			pend_word <= wval;
		end
	end

	// Remote working copy of the holding registers.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < N_HOLD; i++)
				hold_work[i] <= 16'h0000;
		end
		else if (wr_coil && a == COIL_LOCK && bval)
		begin
			for (int i = 0; i < N_HOLD; i++)
				hold_work[i] <= hold_saved[i];
		end
		else if (wr_hold && !set_lo)
		begin
			hold_work[a[4:0]] <= wval;
			if (set_hi)
				hold_work[pend_addr] <= pend_word;
			if (a < DEP_N && hold_work[5'(a + DEP_N)] > wval)
				hold_work[5'(a + DEP_N)] <= wval;
		end
	end

	// Write timer: edits are stored when it expires, then applied at the next cycle start.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wt_armed <= 1'b0;
			wt_cnt <= 32'h00000000;
			apply_req <= 1'b0;
		end
		else
		begin
			if (wr_hold)
			begin
				wt_armed <= 1'b1;
				wt_cnt <= WRITE_CYCLES - 32'd1;
			end
			else if (wt_armed && wt_cnt != 32'h00000000)
				wt_cnt <= wt_cnt - 32'd1;
			else
				wt_armed <= 1'b0;
			if (commit)
				apply_req <= 1'b1;
			else if (cycle_start || cycle_restart)
				apply_req <= 1'b0;
		end
	end

	assign commit = wt_armed && !wr_hold && wt_cnt == 32'h00000000;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < N_HOLD; i++)
			begin
				hold_saved[i] <= 16'h0000;
				hold_active[i] <= 16'h0000;
				hold_snap[i] <= 16'h0000;
			end
			ctrl_rd_data <= 16'h0000;
		end
		else
		begin
			for (int i = 0; i < N_HOLD; i++)
			begin
				if (commit)
					hold_saved[i] <= hold_work[i];
				if (apply_req && (cycle_start || cycle_restart))
					hold_active[i] <= hold_saved[i];
				if (wr_coil && a == COIL_RETRIEVE && bval)
					hold_snap[i] <= hold_saved[i];
			end
			ctrl_rd_data <= hold_active[ctrl_rd_addr];
		end
	end

	// Cycle log trigger and daily production window.
	assign tick = sec_cnt == SECOND_TICKS - 32'd1;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dose_q <= 1'b0;
			cycle_log_append <= 1'b0;
			sec_cnt <= 32'h00000000;
			day_roll <= 1'b0;
			for (int i = 0; i < N_LOG; i++)
				day_log[i] <= 16'h0000;
		end
		else
		begin
			dose_q <= dose_phase;
			cycle_log_append <= dose_q && !dose_phase && return_phase;
			sec_cnt <= tick ? 32'h00000000 : sec_cnt + 32'd1;
			day_roll <= tick && sec_of_day == day_start;
			if (tick)
			begin
				day_log[0] <= today_prod;
				if (sec_of_day == day_start)
				begin
					for (int i = 1; i < N_LOG; i++)
						day_log[i] <= day_log[i - 1];
				end
			end
		end
	end
endmodule : msc_command_handler
`default_nettype wire

// File: tb/msc_asserts.sv
// Concurrent checks on the answer stream and event outputs of the command interpreter.
// Assumes it is bound to msc_command_handler and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module msc_asserts
	import msc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] station_addr,
	input wire logic exc_enable,
	input wire logic fp_busy,
	input wire logic dose_phase,
	input wire logic return_phase,
	input wire logic [16:0] sec_of_day,
	input wire logic [16:0] day_start,
	input wire logic tx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic fp_lock,
	input wire logic cycle_log_append,
	input wire logic day_roll
);
	logic [8:0] idx;
	logic [7:0] fc_seen;
	logic [7:0] own_st;
	assign own_st = (station_addr == 8'h00 || station_addr > STATION_MAX) ?
		STATION_DEF : station_addr;
	// Counts answer bytes taken by the framer within one answer.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			idx <= 9'h000;
		else if (tx_valid && tx_ready)
			idx <= tx_last ? 9'h000 : idx + 9'h001;
	end
	// Keeps the function byte of the answer under way.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			fc_seen <= 8'h00;
		else if (tx_valid && tx_ready && idx == 9'h001)
			fc_seen <= tx_data;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_stall;
		tx_valid && !tx_ready;
	endsequence
	sequence s_held;
		tx_valid && $stable(tx_data) && $stable(tx_last);
	endsequence
	a_hold_stall: assert property (s_stall |=> s_held)
		else $error("answer byte changed while stalled");
	a_last_drop: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
		else $error("answer continued after its last byte");
	a_station_echo: assert property (tx_valid && idx == 9'h000 |-> tx_data == own_st)
		else $error("answer carries a wrong station byte");
	a_exc_gated: assert property (tx_valid && idx == 9'h001 && tx_data[7] |-> exc_enable)
		else $error("exception sent while reporting is off");
	a_exc_form: assert property (tx_valid && idx == 9'h002 && fc_seen[7] |->
		tx_last && tx_data inside {[EXC_ILL_FUNC:EXC_DEV_FAIL]})
		else $error("malformed exception answer");
	a_len_cap: assert property (tx_valid |-> idx < MAX_FRAME)
		else $error("answer longer than the frame limit");
	a_log_cause: assert property (cycle_log_append |->
		$past(dose_phase, 2) && !$past(dose_phase) && $past(return_phase))
		else $error("cycle record without a dosing to return move");
	a_roll_cause: assert property (day_roll |-> $past(sec_of_day) == $past(day_start))
		else $error("daily roll away from the day boundary");
	a_lock_gate: assert property ($rose(fp_lock) |-> !$past(fp_busy))
		else $error("lock taken while the front panel held the dataset");
endmodule : msc_asserts
`default_nettype wire

// File: tb/msc_host_model.sv
// Behavioural serial master seen through the framer: sends payload frames, takes answers.
// Assumes the interpreter's framer-side handshake on clk_sys; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module msc_host_model (
	input wire logic clk_sys,
	input wire logic ascii_mode,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	output logic [9:0] rx_chars,
	output logic tx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last
);
	bit slow = 1'b0;
	int skew = 0;
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_end = 1'b0;
		rx_chars = 10'h000;
		tx_ready = 1'b1;
	end
	// Sends one frame, then gathers the answer; a slow master stalls every other cycle.
	task automatic xfer(input logic [7:0] rq[$], output logic [7:0] rsp[$], output bit fin);
		fin = 1'b0;
		rsp = {};
		foreach (rq[i])
		begin
			@(negedge clk_sys);
			rx_valid = 1'b1;
			rx_data = rq[i];
		end
		@(negedge clk_sys);
		rx_valid = 1'b0;
		rx_data = ~rx_data;
		rx_end = 1'b1;
		rx_chars = 10'(rq.size() * (ascii_mode ? 2 : 1) + skew);
		@(negedge clk_sys);
		rx_end = 1'b0;
		for (int n = 0; n < 200 && !fin; n++)
		begin
			@(negedge clk_sys);
			tx_ready = slow ? n[0] : 1'b1;
			if (tx_valid === 1'b1 && tx_ready)
			begin
				rsp.push_back(tx_data);
				fin = (tx_last === 1'b1);
			end
		end
	endtask : xfer
endmodule : msc_host_model
`default_nettype wire

// File: tb/msc_command_handler_bench.sv
// Self-checking bench: frames go in through the master model, answers and events are compared.
// Assumes the interpreter package and a checker module bound below.
`timescale 1ns/1ps
`default_nettype none
`define MSC_CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) \
	begin errors++; $display("mismatch %0t %s", $time, m); end end
module msc_command_handler_bench;
	import msc_pkg::*;
	typedef logic [7:0] msc_bytes_t[$];
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic ascii_mode = 1'b0, exc_enable = 1'b1, fp_busy = 1'b0, cycle_start = 1'b0;
	logic dose_phase = 1'b0, return_phase = 1'b0, cycle_restart = 1'b0;
	logic [7:0] station_addr = 8'h05;
	logic [15:0] disc_live = 16'h1234, today_prod = 16'h0042;
	logic [16:0] sec_of_day = 17'h00000, day_start = 17'h00005;
	logic [4:0] ctrl_rd_addr = 5'h08;
	logic rx_valid, rx_end, tx_ready, tx_valid, tx_last, fp_lock, cycle_log_append, day_roll;
	logic [7:0] rx_data, tx_data;
	logic [9:0] rx_chars;
	logic [15:0] ctrl_rd_data;
	int errors = 0, cmp_count = 0, n_app = 0, n_roll = 0;
	always #4 clk_sys = ~clk_sys;
	always @(negedge clk_sys)
	begin
		if (cycle_log_append === 1'b1)
			n_app++;
		if (day_roll === 1'b1)
			n_roll++;
	end
	msc_host_model host (.clk_sys, .ascii_mode, .rx_valid, .rx_data, .rx_end, .rx_chars,
		.tx_ready, .tx_valid, .tx_data, .tx_last);
	msc_command_handler #(.WRITE_CYCLES(20), .SECOND_TICKS(10)) dut (.clk_sys, .reset_n,
		.rx_valid, .rx_data, .rx_end, .rx_chars, .ascii_mode, .station_addr, .exc_enable,
		.fp_busy, .disc_live, .cycle_start, .cycle_restart, .dose_phase, .return_phase,
		.sec_of_day, .day_start, .today_prod, .ctrl_rd_addr, .tx_ready, .tx_valid, .tx_data,
		.tx_last, .fp_lock, .ctrl_rd_data, .cycle_log_append, .day_roll);
	task automatic tally_and_finish();
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic run(input logic [7:0] st, input msc_bytes_t rq, input msc_bytes_t ex);
		msc_bytes_t got;
		bit fin;
		rq.push_front(st);
		if (ex.size() > 0)
			ex.push_front(st);
		host.xfer(rq, got, fin);
		`MSC_CHK(got.size(), ex.size(), "answer length")
		foreach (ex[i])
			`MSC_CHK(got[i], ex[i], "answer byte")
		if (ex.size() > 0 && !fin)
		begin
			errors++;
			$display("mismatch %0t no answer", $time);
			tally_and_finish();
		end
	endtask : run
	task automatic echo(input msc_bytes_t q);
		run(8'h05, q, q);
	endtask : echo
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : idle
	initial
	begin
		idle(10);
		reset_n = 1'b1;
		idle(1);
		run(8'h05, '{8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h87, 8'h01});
		echo('{8'h05, 8'h00, 8'h00, 8'hff, 8'h00});
		disc_live = 16'hffff;
		run(8'h05, '{8'h02, 8'h00, 8'h00, 8'h00, 8'h10}, '{8'h02, 8'h02, 8'h34, 8'h12});
		fp_busy = 1'b1;
		run(8'h05, '{8'h05, 8'h00, 8'h01, 8'hff, 8'h00}, '{8'h85, 8'h04});
		run(8'h05, '{8'h04, 8'h03, 8'he8, 8'h00, 8'h03},
			'{8'h04, 8'h06, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h01});
		fp_busy = 1'b0;
		echo('{8'h05, 8'h00, 8'h01, 8'hff, 8'h00});
		`MSC_CHK(fp_lock, 1'b1, "lock not held")
		echo('{8'h06, 8'h00, 8'h00, 8'h00, 8'h07});
		echo('{8'h06, 8'h00, 8'h08, 8'h00, 8'h05});
		echo('{8'h06, 8'h00, 8'h00, 8'h00, 8'h03});
		idle(30);
		`MSC_CHK(ctrl_rd_data, 16'h0000, "edit applied early")
		cycle_start = 1'b1;
		idle(1);
		cycle_start = 1'b0;
		idle(3);
		`MSC_CHK(ctrl_rd_data, 16'h0003, "dependent not adjusted")
		echo('{8'h05, 8'h00, 8'h00, 8'hff, 8'h00});
		run(8'h05, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h03}, '{8'h01, 8'h01, 8'h00});
		run(8'h05, '{8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h03, 8'h02, 8'h00, 8'h03});
		run(8'h05, '{8'h10, 8'h00, 8'h10, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02},
			'{8'h10, 8'h00, 8'h10, 8'h00, 8'h02});
		run(8'h05, '{8'h06, 8'h00, 8'h11, 8'h00, 8'h05}, '{8'h86, 8'h04});
		run(8'h05, '{8'h03, 8'h00, 8'h1e, 8'h00, 8'h04}, '{8'h83, 8'h02});
		run(8'h05, '{8'h04, 8'h03, 8'he8, 8'h00, 8'h03},
			'{8'h04, 8'h06, 8'h00, 8'h0a, 8'h00, 8'h04, 8'h00, 8'h20});
		run(8'h05, '{8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00}, '{8'h83, 8'h03});
		run(8'h05, '{8'h10, 8'h00, 8'h10, 8'h00, 8'h01, 8'h03, 8'h00, 8'h07, 8'h00},
			'{8'h90, 8'h03});
		run(8'h05, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h81, 8'h03});
		ctrl_rd_addr = 5'h10;
		cycle_restart = 1'b1;
		idle(1);
		cycle_restart = 1'b0;
		idle(3);
		`MSC_CHK(ctrl_rd_data, 16'h0001, "set not applied on restart")
		ascii_mode = 1'b1;
		host.skew = -1;
		run(8'h05, '{8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h83, 8'h03});
		host.skew = 0;
		run(8'h05, '{8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h03, 8'h02, 8'h00, 8'h03});
		ascii_mode = 1'b0;
		run(8'h05, '{8'h0f, 8'h00, 8'h03, 8'h00, 8'h02, 8'h01, 8'h03},
			'{8'h0f, 8'h00, 8'h03, 8'h00, 8'h02});
		run(8'h05, '{8'h01, 8'h00, 8'h03, 8'h00, 8'h02}, '{8'h01, 8'h01, 8'h03});
		host.slow = 1'b1;
		run(8'h05, '{8'h03, 8'h00, 8'h00, 8'h00, 8'h02},
			'{8'h03, 8'h04, 8'h00, 8'h03, 8'h00, 8'h00});
		host.slow = 1'b0;
		exc_enable = 1'b0;
		run(8'h05, '{8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, '{});
		exc_enable = 1'b1;
		run(8'h00, '{8'h05, 8'h00, 8'h02, 8'hff, 8'h00}, '{});
		`MSC_CHK(fp_lock, 1'b0, "broadcast not executed")
		run(8'h06, '{8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{});
		dose_phase = 1'b1;
		return_phase = 1'b1;
		idle(2);
		dose_phase = 1'b0;
		idle(3);
		`MSC_CHK(n_app, 1, "cycle record count")
		return_phase = 1'b0;
		dose_phase = 1'b1;
		idle(2);
		dose_phase = 1'b0;
		idle(3);
		`MSC_CHK(n_app, 1, "cycle record outside return")
		sec_of_day = 17'h00005;
		idle(10);
		sec_of_day = 17'h00006;
		idle(12);
		`MSC_CHK(n_roll, 1, "daily roll count")
		run(8'h05, '{8'h04, 8'h00, 8'h64, 8'h00, 8'h02},
			'{8'h04, 8'h04, 8'h00, 8'h42, 8'h00, 8'h42});
		tally_and_finish();
	end
endmodule : msc_command_handler_bench
bind msc_command_handler msc_asserts u_chk (.clk_sys, .reset_n, .station_addr, .exc_enable,
	.fp_busy, .dose_phase, .return_phase, .sec_of_day, .day_start, .tx_ready, .tx_valid,
	.tx_data, .tx_last, .fp_lock, .cycle_log_append, .day_roll);
`default_nettype wire
